/* File: core/modbus_node_data_server.sv */
// Modbus server answering coil, discrete input and input register reads
//
// What this block does
// - Serve 01H as coil status read, echo
// - Answer only own address within 1 to 247
// - Coil reads above 100 are dropped
// - Relay node owns coils (id-1)*2 onward
// - Pack bits eight per byte, low first
// - Byte count from requested bit quantity
// - Serial frames carry CRC, low byte first
// - Serve 02H as discrete input read
// - Discrete reads above 200 are dropped
// - Input node owns inputs (id-1)*4 onward
// - Serve 04H as sensor input register read
// - Registers at 40000 plus (id-1)*7
// - Max 50 nodes, 350 registers, else drop
// - Address and quantity sent high byte first
// - Seven words per node in fixed order
// - TCP command counter echoed unchanged
// - TCP zero field follows the counter
// - TCP length counts following bytes
`include "node_server_map.svh"

module modbus_node_data_server
  import node_server_pkg::*;
(
  // Clock and reset
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  // Configuration
  input  wire logic [7:0]              unit_addr_i,
  input  wire logic                    tcp_mode_i,
  // Request byte stream
  input  wire logic [7:0]              rx_byte_i,
  input  wire logic                    rx_valid_i,
  input  wire logic                    rx_sof_i,
  output logic                         rx_ready_o,
  // Reply byte stream
  output logic [7:0]                   tx_byte_o,
  output logic                         tx_valid_o,
  output logic                         tx_last_o,
  input  wire logic                    tx_ready_i,
  // Node status and measurements
  input  wire logic [`COIL_BITS-1:0]   coil_state_i,
  input  wire logic [`INPUT_BITS-1:0]  input_state_i,
  input  wire logic                    meas_wr_i,
  input  wire logic [5:0]              meas_node_i,
  input  wire logic [2:0]              meas_sel_i,
  input  wire logic [15:0]             meas_data_i,
  // Status
  output logic                         frame_drop_o
);

  // --------------------------------------------------------------------
  // CRC over one byte, reflected polynomial
  // --------------------------------------------------------------------
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // --------------------------------------------------------------------
  // Measurement store
  // --------------------------------------------------------------------
  logic [15:0] meas_mem [0:`IREG_WORDS-1];
  logic [8:0]  wr_idx;
  logic        wr_ok;

  assign wr_idx = 9'((9'(meas_node_i) - `NODE_ONE) * `NODE_REGS)
                + 9'(meas_sel_i);
  // only nodes 1 to 50 stored
  assign wr_ok  = meas_wr_i && meas_node_i != 6'h00
               && meas_node_i <= `NODE_MAX && meas_sel_i <= `REG_SEL_MAX;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `IREG_WORDS; i++) begin
        meas_mem[i] <= 16'h0000;
      end
    end else if (wr_ok) begin
      // word order set by select index
      meas_mem[wr_idx] <= meas_data_i;
    end
  end

  // --------------------------------------------------------------------
  // Server state
  // --------------------------------------------------------------------
  state_e      state_q, state_d;
  logic [7:0]  buf_q [0:11];
  logic [7:0]  buf_d [0:11];
  logic [3:0]  cnt_q, cnt_d;
  logic [15:0] rx_crc_q, rx_crc_d;
  logic [15:0] tx_crc_q, tx_crc_d;
  req_s        req_q, req_d;
  logic [7:0]  bc_q, bc_d;
  logic        tcp_q, tcp_d;
  logic [9:0]  idx_q, idx_d;
  logic [7:0]  tx_byte_q, tx_byte_d;
  logic        tx_valid_q, tx_valid_d;
  logic        tx_last_q, tx_last_d;
  logic        rx_ready_q, rx_ready_d;
  logic        drop_q, drop_d;

  logic [3:0]  need;
  logic [3:0]  ofs;
  req_s        rq;
  logic [16:0] last_end;
  logic        ok;
  logic [9:0]  total;
  logic [9:0]  pos;
  logic [7:0]  p;
  logic [7:0]  cur;
  logic [8:0]  w;
  int          k;

  always_comb begin
    state_d    = state_q;
    buf_d      = buf_q;
    cnt_d      = cnt_q;
    rx_crc_d   = rx_crc_q;
    tx_crc_d   = tx_crc_q;
    req_d      = req_q;
    bc_d       = bc_q;
    tcp_d      = tcp_q;
    idx_d      = idx_q;
    tx_byte_d  = tx_byte_q;
    tx_valid_d = tx_valid_q;
    tx_last_d  = tx_last_q;
    drop_d     = 1'b0;
    need       = tcp_mode_i ? `TCP_REQ_LEN : `RTU_REQ_LEN;
    ofs        = tcp_mode_i ? `TCP_PDU_OFS : 4'h0;
    // start and quantity high byte first
    rq.tid     = {buf_q[0], buf_q[1]};
    rq.unit    = buf_q[ofs];
    rq.fc      = buf_q[ofs + 4'h1];
    rq.start   = {buf_q[ofs + 4'h2], buf_q[ofs + 4'h3]};
    rq.qty     = {buf_q[ofs + 4'h4], buf_q[ofs + 4'h5]};
    last_end   = 17'(rq.start) + 17'(rq.qty);
    ok         = 1'b0;
    total      = tcp_q ? (`TCP_HDR_LEN + 10'(bc_q))
                       : (`RTU_FIXED_LEN + 10'(bc_q));
    pos        = tcp_q ? idx_q : (idx_q + `RTU_POS_SHIFT);
    p          = 8'(pos - `TCP_HDR_LEN);
    w          = 9'(17'(req_q.start) - `IREG_BASE) + 9'(p >> 1);
    cur        = 8'h00;
    k          = 0;

    case (state_q)
      ST_RECV: begin
        if (rx_valid_i && rx_ready_q) begin
          if (rx_sof_i) begin
            buf_d[0] = rx_byte_i;
            cnt_d    = 4'h1;
            rx_crc_d = crc_byte(`CRC_INIT, rx_byte_i);
            if (need == 4'h1) begin
              state_d = ST_CHECK;
            end
          end else if (cnt_q != 4'h0 && cnt_q < need) begin
            buf_d[cnt_q] = rx_byte_i;
            cnt_d        = cnt_q + 4'h1;
            rx_crc_d     = crc_byte(rx_crc_q, rx_byte_i);
            if (cnt_q + 4'h1 == need) begin
              state_d = ST_CHECK;
            end
          end
        end
      end
      ST_CHECK: begin
        ok = rq.unit >= `UNIT_MIN && rq.unit <= `UNIT_MAX
          && rq.unit == unit_addr_i && rq.qty != 16'h0000;
        if (!tcp_mode_i && rx_crc_q != 16'h0000) begin
          ok = 1'b0;
        end
        if (tcp_mode_i && ({buf_q[2], buf_q[3]} != 16'h0000
            || {buf_q[4], buf_q[5]} != `TCP_REQ_FOLLOW)) begin
          ok = 1'b0;
        end
        case (rq.fc)
          `FC_COILS: begin
            if (17'(rq.qty) > `COIL_MAX || last_end > `COIL_MAX) begin
              ok = 1'b0;
            end
          end
          `FC_INPUTS: begin
            if (17'(rq.qty) > `INPUT_MAX || last_end > `INPUT_MAX) begin
              ok = 1'b0;
            end
          end
          `FC_IREGS: begin
            if (17'(rq.start) < `IREG_BASE || last_end > `IREG_END
                || 17'(rq.qty) > `IREG_QTY_MAX) begin
              ok = 1'b0;
            end
          end
          default: begin
            ok = 1'b0;
          end
        endcase
        bc_d = (rq.fc == `FC_IREGS)
             ? 8'(rq.qty << 1)
             : 8'((17'(rq.qty) + `BITS_ROUND) >> 3);
        req_d    = rq;
        tcp_d    = tcp_mode_i;
        idx_d    = 10'h000;
        tx_crc_d = `CRC_INIT;
        cnt_d    = 4'h0;
        drop_d   = !ok;
        state_d  = ok ? ST_SEND : ST_RECV;
      end
      ST_SEND: begin
        if (pos < `TCP_HDR_LEN) begin
          case (pos[3:0])
            4'h0: cur = req_q.tid[15:8];
            4'h1: cur = req_q.tid[7:0];
            4'h5: cur = `PDU_HDR_LEN + bc_q;
            4'h6: cur = req_q.unit;
            4'h7: cur = req_q.fc;
            4'h8: cur = bc_q;
            default: cur = 8'h00;
          endcase
        end else if (p < bc_q) begin
          if (req_q.fc == `FC_IREGS) begin
            cur = p[0] ? meas_mem[w][7:0] : meas_mem[w][15:8];
          end else begin
            for (int b = 0; b < 8; b++) begin
              k = int'(req_q.start) + int'(p) * 8 + b;
              if (int'(p) * 8 + b < int'(req_q.qty)) begin
                if (req_q.fc == `FC_COILS) begin
                  cur[b] = (k < `COIL_BITS) ? coil_state_i[k] : 1'b0;
                end else begin
                  cur[b] = (k < `INPUT_BITS) ? input_state_i[k] : 1'b0;
                end
              end
            end
          end
        end else if (p == bc_q) begin
          cur = tx_crc_q[7:0];
        end else begin
          cur = tx_crc_q[15:8];
        end

        if (!tx_valid_q || tx_ready_i) begin
          if (idx_q < total) begin
            tx_byte_d  = cur;
            tx_valid_d = 1'b1;
            tx_last_d  = (idx_q == total - 10'h001);
            idx_d      = idx_q + 10'h001;
            if (pos < `TCP_HDR_LEN || p < bc_q) begin
              tx_crc_d = crc_byte(tx_crc_q, cur);
            end
          end else begin
            tx_valid_d = 1'b0;
            tx_last_d  = 1'b0;
            state_d    = ST_RECV;
          end
        end
      end
      default: begin
        state_d = ST_RECV;
      end
    endcase
    rx_ready_d = (state_d == ST_RECV);
  end

  // Bytes outside a frame start are ignored until the next start
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q    <= ST_RECV;
      for (int i = 0; i < 12; i++) begin
        buf_q[i] <= 8'h00;
      end
      cnt_q      <= 4'h0;
      rx_crc_q   <= `CRC_INIT;
      tx_crc_q   <= `CRC_INIT;
      req_q      <= '0;
      bc_q       <= 8'h00;
      tcp_q      <= 1'b0;
      idx_q      <= 10'h000;
      tx_byte_q  <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_last_q  <= 1'b0;
      rx_ready_q <= 1'b0;
      drop_q     <= 1'b0;
    end else begin
      state_q    <= state_d;
      buf_q      <= buf_d;
      cnt_q      <= cnt_d;
      rx_crc_q   <= rx_crc_d;
      tx_crc_q   <= tx_crc_d;
      req_q      <= req_d;
      bc_q       <= bc_d;
      tcp_q      <= tcp_d;
      idx_q      <= idx_d;
      tx_byte_q  <= tx_byte_d;
      tx_valid_q <= tx_valid_d;
      tx_last_q  <= tx_last_d;
      rx_ready_q <= rx_ready_d;
      drop_q     <= drop_d;
    end
  end

  assign rx_ready_o   = rx_ready_q;
  assign tx_byte_o    = tx_byte_q;
  assign tx_valid_o   = tx_valid_q;
  assign tx_last_o    = tx_last_q;
  assign frame_drop_o = drop_q;

endmodule

/* File: core/node_server_map.svh */
// Constants for the Modbus node data server: codes, limits, frame layout
`ifndef NODE_SERVER_MAP_SVH
`define NODE_SERVER_MAP_SVH

// ----------------------------------------------------------------------
// Function codes and unit address range
// ----------------------------------------------------------------------
`define FC_COILS      8'h01
`define FC_INPUTS     8'h02
`define FC_IREGS      8'h04
`define UNIT_MIN      8'h01
`define UNIT_MAX      8'hF7

// ----------------------------------------------------------------------
// Address map and quantity limits
// ----------------------------------------------------------------------
`define COIL_BITS     100
`define INPUT_BITS    200
`define IREG_WORDS    350
`define COIL_MAX      17'h00064
`define INPUT_MAX     17'h000C8
`define IREG_BASE     17'h09C40
`define IREG_END      17'h09D9E
`define IREG_QTY_MAX  17'h0007D
`define NODE_MAX      6'h32
`define NODE_REGS     9'h007
`define NODE_ONE      9'h001
`define REG_SEL_MAX   3'h6

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define RTU_REQ_LEN   4'h8
`define TCP_REQ_LEN   4'hC
`define TCP_PDU_OFS   4'h6
`define TCP_REQ_FOLLOW 16'h0006
`define TCP_HDR_LEN   10'h009
`define RTU_POS_SHIFT 10'h006
`define RTU_FIXED_LEN 10'h005
`define PDU_HDR_LEN   8'h03
`define BITS_ROUND    17'h00007
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'hA001

`endif

/* File: core/node_server_pkg.sv */
// Types shared by the Modbus node data server
package node_server_pkg;

  typedef enum logic [1:0] {
    ST_RECV,
    ST_CHECK,
    ST_SEND
  } state_e;

  typedef struct packed {
    logic [15:0] tid;
    logic [7:0]  unit;
    logic [7:0]  fc;
    logic [15:0] start;
    logic [15:0] qty;
  } req_s;

endpackage

/* File: dv/master_station_model.sv */
// Master station model: sends request frames, takes reply bytes
module master_station_model (
  // From the bench (clock, pace) and the server
  input  wire logic       sys_clk_i,
  input  wire logic       slow_i,
  input  wire logic       rx_ready_i,
  input  wire logic [7:0] tx_byte_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_last_i,
  input  wire logic       drop_i,
  // To the server
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            rx_sof_o,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    rx_byte_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_sof_o   = 1'b0;
    tx_ready_o = 1'b0;
  end

  // one whole request at a time
  task automatic exchange(input logic [7:0] req[$],
                          output logic [7:0] rsp[$], output logic dropped);
    rsp     = {};
    dropped = 1'b0;
    while (!rx_ready_i) @(posedge sys_clk_i);
    foreach (req[i]) begin
      rx_byte_o  <= req[i];
      rx_sof_o   <= (i == 0);
      rx_valid_o <= 1'b1;
      do @(posedge sys_clk_i); while (!rx_ready_i);
    end
    // Released data lines must not keep showing the last byte
    rx_byte_o  <= ~req[req.size()-1];
    rx_valid_o <= 1'b0;
    rx_sof_o   <= 1'b0;
    for (int n = 0; n < 300; n++) begin
      tx_ready_o <= !(slow_i && n[0]);
      @(posedge sys_clk_i);
      if (drop_i) begin
        dropped = 1'b1;
        break;
      end
      if (tx_valid_i && tx_ready_o) begin
        rsp.push_back(tx_byte_i);
        if (tx_last_i) break;
      end
    end
    tx_ready_o <= 1'b0;
  endtask
endmodule

/* File: dv/node_server_props.sv */
// Concurrent checks on the node data server ports
module node_server_props (
  // Clock, reset, configuration
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic [7:0] unit_addr_i,
  input wire logic       tcp_mode_i,
  // Streams
  input wire logic [7:0] rx_byte_i,
  input wire logic       rx_valid_i,
  input wire logic       rx_sof_i,
  input wire logic       rx_ready_o,
  input wire logic [7:0] tx_byte_o,
  input wire logic       tx_valid_o,
  input wire logic       tx_last_o,
  input wire logic       tx_ready_i,
  input wire logic       frame_drop_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [3:0] cnt_q, cnt_d;
  logic [7:0] unit_q, unit_d;
  logic [4:0] idx_q, idx_d;
  logic       take, put;

  assign take = rx_valid_i && rx_ready_o;
  assign put  = tx_valid_o && tx_ready_i;

  always_comb begin
    cnt_d  = take ? (rx_sof_i ? 4'h1 : cnt_q + 4'h1) : cnt_q;
    unit_d = (take && cnt_d == (tcp_mode_i ? 4'h7 : 4'h1)) ? rx_byte_i
                                                            : unit_q;
    idx_d  = put ? (tx_last_o ? 5'h00 : idx_q + 5'h01) : idx_q;
  end

  always_ff @(posedge sys_clk_i) begin
    cnt_q  <= rst_n_i ? cnt_d : 4'h0;
    unit_q <= rst_n_i ? unit_d : 8'h00;
    idx_q  <= rst_n_i ? idx_d : 5'h00;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  reset_quiet_a: assert property ($rose(rst_n_i) |->
    !rx_ready_o && !tx_valid_o && !frame_drop_o) else $error("busy in reset");
  own_unit_a: assert property ($rose(tx_valid_o) |->
    unit_q == unit_addr_i && unit_q inside {[8'h01:8'hF7]})
    else $error("reply for foreign unit");
  echo_unit_a: assert property ($rose(tx_valid_o) && !tcp_mode_i |->
    tx_byte_o == unit_q) else $error("unit not echoed");
  answer_time_a: assert property (
    take && cnt_d == (tcp_mode_i ? 4'hC : 4'h8) |->
    (##2 frame_drop_o) or (##3 tx_valid_o)) else $error("no answer");
  drop_pulse_a: assert property (frame_drop_o |=> !frame_drop_o)
    else $error("drop too long");
  drop_silent_a: assert property (frame_drop_o |->
    !tx_valid_o ##1 !tx_valid_o) else $error("reply after drop");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=>
    tx_valid_o && $stable(tx_byte_o) && $stable(tx_last_o))
    else $error("reply byte moved");
  one_request_a: assert property (tx_valid_o |-> !rx_ready_o)
    else $error("takes while replying");
  reply_end_a: assert property (put && tx_last_o |=>
    !tx_valid_o ##1 rx_ready_o) else $error("bad reply end");
  tcp_zero_a: assert property (tcp_mode_i && tx_valid_o &&
    idx_q inside {5'h02, 5'h03, 5'h04} |-> tx_byte_o == 8'h00)
    else $error("header byte not zero");

  cover property (frame_drop_o);
  cover property (put && tx_last_o && tcp_mode_i);
  cover property (put && tx_last_o && !tcp_mode_i);
endmodule

bind modbus_node_data_server node_server_props props_u (
  .sys_clk_i, .rst_n_i, .unit_addr_i, .tcp_mode_i, .rx_byte_i, .rx_valid_i,
  .rx_sof_i, .rx_ready_o, .tx_byte_o, .tx_valid_o, .tx_last_o, .tx_ready_i,
  .frame_drop_o
);

/* File: dv/tb_modbus_node_data_server.sv */
// Self-checking bench for the Modbus node data server
module tb_modbus_node_data_server;
  timeunit 1ns;
  timeprecision 1ns;

  typedef logic [7:0] bytes_t[$];

  logic         sys_clk_i = 1'b0;
  logic         rst_n_i, tcp_mode_i, slow, frame_drop_o;
  logic [7:0]   rx_byte_i, tx_byte_o, unit_addr_i;
  logic         rx_valid_i, rx_sof_i, rx_ready_o;
  logic         tx_valid_o, tx_last_o, tx_ready_i, meas_wr_i;
  logic [99:0]  coil_state_i;
  logic [199:0] input_state_i;
  logic [5:0]   meas_node_i;
  logic [2:0]   meas_sel_i;
  logic [15:0]  meas_data_i;
  int           compares, miscompares, cycles;

  always #50 sys_clk_i = ~sys_clk_i;

  modbus_node_data_server dut_u (
    .sys_clk_i, .rst_n_i, .unit_addr_i, .tcp_mode_i, .rx_byte_i,
    .rx_valid_i, .rx_sof_i, .rx_ready_o, .tx_byte_o, .tx_valid_o,
    .tx_last_o, .tx_ready_i, .coil_state_i, .input_state_i, .meas_wr_i,
    .meas_node_i, .meas_sel_i, .meas_data_i, .frame_drop_o
  );

  master_station_model master_u (
    .sys_clk_i, .slow_i(slow), .rx_ready_i(rx_ready_o), .tx_byte_i(tx_byte_o),
    .tx_valid_i(tx_valid_o), .tx_last_i(tx_last_o), .drop_i(frame_drop_o),
    .rx_byte_o(rx_byte_i), .rx_valid_o(rx_valid_i), .rx_sof_o(rx_sof_i),
    .tx_ready_o(tx_ready_i)
  );

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Cut a hang short; the run needs only a few hundred cycles
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic cmp8(input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  task automatic cmp_frame(input bytes_t exp, input bytes_t got);
    cmp8(8'(exp.size()), 8'(got.size()));
    foreach (exp[i]) if (i < got.size()) cmp8(exp[i], got[i]);
  endtask

  task automatic add_crc(ref bytes_t q);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endtask

  // No reply expected when exp is empty
  task automatic xfer(input bytes_t req, input bytes_t exp, input logic rtu);
    bytes_t rsp;
    logic   d;
    if (rtu) add_crc(req);
    if (rtu && exp.size() > 0) add_crc(exp);
    master_u.exchange(req, rsp, d);
    cmp8({7'h00, exp.size() == 0}, {7'h00, d});
    cmp_frame(exp, rsp);
  endtask

  task automatic bitread(input logic [7:0] fc, input int start, input int qty);
    bytes_t      req, exp;
    logic [199:0] src;
    logic [7:0]  b;
    src = (fc == 8'h01) ? {100'h0, coil_state_i} : input_state_i;
    req = {unit_addr_i, fc, 8'(start >> 8), 8'(start), 8'(qty >> 8), 8'(qty)};
    exp = {unit_addr_i, fc, 8'((qty + 7) / 8)};
    for (int k = 0; k < (qty + 7) / 8; k++) begin
      for (int i = 0; i < 8; i++)
        b[i] = (8*k+i < qty) ? src[start+8*k+i] : 1'b0;
      exp.push_back(b);
    end
    xfer(req, exp, 1'b1);
  endtask

  function automatic logic [15:0] mval(input int n, input int s);
    return 16'(n * 16'h0101 + s * 16'h0011);
  endfunction

  task automatic regread(input logic [15:0] tid, input int node);
    bytes_t      req, exp;
    logic [15:0] w, a;
    a   = 16'(40000 + (node - 1) * 7);
    req = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h04,
           a[15:8], a[7:0], 8'h00, 8'h07};
    exp = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h11, 8'h01, 8'h04,
           8'h0E};
    for (int s = 0; s < 7; s++) begin
      w = mval(node, s);
      exp.push_back(w[15:8]);
      exp.push_back(w[7:0]);
    end
    xfer(req, exp, 1'b0);
  endtask

  task automatic test_coils();
    coil_state_i <= 100'h9_5A3C_1E2D_4B78_F06A_C35B_2E91;
    @(posedge sys_clk_i);
    bitread(8'h01, 2, 10);
    bitread(8'h01, 0, 100);
    $display("test coils done");
  endtask

  task automatic test_inputs();
    input_state_i <= {4{50'h2_D1E4_B78C_0F35}};
    unit_addr_i   <= 8'hF7;
    slow          <= 1'b1;
    @(posedge sys_clk_i);
    bitread(8'h02, 4, 8);
    bitread(8'h02, 0, 200);
    slow <= 1'b0;
    unit_addr_i <= 8'h01;
    $display("test inputs done");
  endtask

  task automatic test_regs();
    bytes_t req, none, cexp;
    for (int n = 1; n <= 50; n += 49)
      for (int s = 0; s < 7; s++) begin
        @(posedge sys_clk_i);
        meas_wr_i   <= 1'b1;
        meas_node_i <= 6'(n);
        meas_sel_i  <= 3'(s);
        meas_data_i <= mval(n, s);
      end
    @(posedge sys_clk_i);
    meas_wr_i  <= 1'b0;
    tcp_mode_i <= 1'b1;
    regread(16'h0001, 1);
    regread(16'h0002, 50);
    // Length field must announce six following bytes
    req = {8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h04, 8'h9C,
           8'h40, 8'h00, 8'h07};
    xfer(req, none, 1'b0);
    req = {8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, 8'h01, 8'h00,
           8'h00, 8'h00, 8'h0A};
    cexp = {8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h01, 8'h02};
    cexp.push_back(coil_state_i[7:0]);
    cexp.push_back(8'(coil_state_i[9:8]));
    xfer(req, cexp, 1'b0);
    req[2] = 8'h01;
    xfer(req, none, 1'b0);
    tcp_mode_i <= 1'b0;
    $display("test registers done");
  endtask

  task automatic test_refused();
    bytes_t req, none;
    for (int t = 0; t < 7; t++) begin
      case (t)
        0: req = {8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
        1: req = {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h65};
        2: req = {8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'hC9};
        3: req = {8'h01, 8'h04, 8'h9D, 8'h98, 8'h00, 8'h07};
        4: req = {8'hF8, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
        5: req = {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        default: req = {8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01};
      endcase
      // Own address above 247 is still refused
      unit_addr_i <= (t == 4) ? 8'hF8 : 8'h01;
      xfer(req, none, 1'b1);
    end
    req = {8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h0A, 8'hBC, 8'h0E};
    xfer(req, none, 1'b0);
    $display("test refused done");
  endtask

  initial begin
    rst_n_i       <= 1'b0;
    unit_addr_i   <= 8'h01;
    tcp_mode_i    <= 1'b0;
    slow          <= 1'b0;
    coil_state_i  <= 100'h0;
    input_state_i <= 200'h0;
    meas_wr_i     <= 1'b0;
    meas_node_i   <= 6'h00;
    meas_sel_i    <= 3'h0;
    meas_data_i   <= 16'h0000;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    test_coils();
    test_inputs();
    test_regs();
    test_refused();
    report_and_stop();
  end
endmodule
